/* pdl_pkg.sv */
// How it works
// - Sync is one normal frame carrying data 0x55.
// - A valid sync received while disabled enables the port.
// - Sync sets the bit rate used for the following frames.
// - Port clock ticks over the 8-bit sync pattern give the bit period.
// - Falling edge makes the port hold the pin low until its clock is ready.
// - After enable sync the port awaits the first instruction, no extra sync.
// - Wake hold lasts 256 cycles of 32 MHz plus calibration readout.
// - No sync start within 65536 port ticks after release disables the port.
// - Sync overflowing the count or shorter than minimum disables the port at start-up, else sets a frame error.
// - Start-up self-disable drops every power request; new wake needed.
// - Writing the disable bit resets the system and disables the port.
// - Parity, contention, frame and access time-out errors set a signature.
// - Any error enters error state; only a break or a disable write then leaves it.
// - Guard field sets idle bits inserted before each response byte.
// - Guard time is a minimum gap; a late response lengthens it.
// - Guard field defaults to two, giving three idle bits; programmer adds its own.
// - Each instruction is one byte; a sync precedes it only after a break, a disable or a sync request.
// - A break returns the guard field to its default, divider to 4 MHz selection.
// - Port clock starts at divider selection 0x3 after reset or a disable write.
package pdl_pkg;

  localparam int CLK_NS = 10;

  // Register offsets and fields
  localparam logic [3:0] GUARD_OFF = 4'h0;
  localparam logic [3:0] DIS_OFF   = 4'h1;
  localparam logic [3:0] STATB_OFF = 4'h2;
  localparam logic [3:0] ASI_OFF   = 4'h3;
  localparam logic [3:0] STATE_OFF = 4'h4;
  localparam int         DIS_BIT   = 2;
  localparam logic [2:0] GT_RESET  = 3'h2;
  localparam logic [1:0] DIV_RESET = 2'h3;

  // Wake hold: oscillator start plus calibration readout
  localparam int WAKE_OSC_CYC = 256;
  localparam int OSC_MHZ      = 32;
  localparam int WAKE_NS      = WAKE_OSC_CYC * 1000 / OSC_MHZ;
  localparam int WAKE_CYC     = (WAKE_NS + CLK_NS - 1) / CLK_NS;

  // Sync measurement
  localparam int         BAUD_W    = 16;
  localparam int         FRAC_W    = 3;
  localparam logic [7:0] SYNC_DATA = 8'h55;
  localparam logic [2:0] SYNC_FALL = 3'h4;
  localparam logic [15:0] MIN_SYNC = 16'h0010;
  localparam logic [3:0] FRAME_BITS = 4'hc;

  typedef enum logic [3:0] {
    ST_DIS   = 4'h0,
    ST_WAKE  = 4'h1,
    ST_WAIT  = 4'h2,
    ST_SYNC  = 4'h3,
    ST_IDLE  = 4'h4,
    ST_RX    = 4'h5,
    ST_GUARD = 4'h6,
    ST_TX    = 4'h7,
    ST_ERR   = 4'h8
  } pdl_state_t;

  typedef enum logic [2:0] {
    SIG_NONE       = 3'h0,
    SIG_PARITY     = 3'h1,
    SIG_FRAME      = 3'h2,
    SIG_ACCESS     = 3'h3,
    SIG_CONTENTION = 3'h4
  } pdl_sig_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } pdl_rx_t;

  // System clocks per port tick for divider settings 0..3
  function automatic logic [4:0] div_ratio(input logic [1:0] sel);
    case (sel)
      2'h0:    div_ratio = 5'h03;
      2'h1:    div_ratio = 5'h06;
      2'h2:    div_ratio = 5'h0c;
      default: div_ratio = 5'h19;
    endcase
  endfunction

endpackage

/* pdl_sync_meter.sv */
`timescale 1ns/1ns
module pdl_sync_meter #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         srst,
  // Control
  input  wire logic         tick,
  input  wire logic         arm,
  input  wire logic         line,
  // Result
  output logic              done,
  output logic              bad,
  output logic [W-1:0]      count
);

  logic       run;
  logic       line_q;
  logic [2:0] falls;
  logic       fall;

  assign fall = line_q & ~line;

  always_ff @(posedge sys_clk) begin
    line_q <= line;
  end

  // Count ticks from the start edge to the fifth falling edge: 8 bits
  always_ff @(posedge sys_clk) begin
    if (srst || !arm) begin
      run   <= 1'b0;
      falls <= 3'h0;
      count <= '0;
      done  <= 1'b0;
      bad   <= 1'b0;
    end else if (!run && !done && !bad) begin
      // Armed a cycle after the start edge, so take the low start bit
      if (!line) begin
        run <= 1'b1;
      end
    end else if (run) begin
      if (fall) begin
        falls <= falls + 3'h1;
        if (falls == pdl_pkg::SYNC_FALL - 3'h1) begin
          run <= 1'b0;
          if (count < pdl_pkg::MIN_SYNC) begin
            bad <= 1'b1;
          end else begin
            done <= 1'b1;
          end
        end
      end
      if (tick) begin
        if (&count) begin
          run <= 1'b0;
          bad <= 1'b1;
        end else begin
          count <= count + 1'b1;
        end
      end
    end
  end

endmodule

/* pdl_link.sv */
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
module pdl_link #(
  parameter int TIMEOUT_TICKS = 65536,
  parameter int CAL_CYC       = 16
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             srst,
  // Register port
  input  wire logic [3:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic [7:0]            reg_rdata,
  // Debug pin
  input  wire logic             pin_in,
  output logic                  pin_out,
  output logic                  pin_oe,
  // Instruction layer
  output pdl_pkg::pdl_rx_t      rx,
  input  wire logic             sync_req,
  input  wire logic             tx_valid,
  input  wire logic [7:0]       tx_data,
  output logic                  tx_done,
  input  wire logic             acc_timeout,
  // System
  output logic                  clk_req,
  output logic                  sys_reset_req,
  output logic                  port_enabled,
  output logic                  error_active
);

  localparam int TO_W = $clog2(TIMEOUT_TICKS + 1);
  localparam int WAKE_TOTAL = pdl_pkg::WAKE_CYC + CAL_CYC;
  localparam int BW = pdl_pkg::BAUD_W;
  localparam int PW = BW - pdl_pkg::FRAC_W;

  pdl_pkg::pdl_state_t state;
  pdl_pkg::pdl_sig_t   sig;
  logic [2:0]          gt_field;
  logic [1:0]          div_sel;
  logic [4:0]          tdiv;
  logic                tick;
  logic                pin_q;
  logic                fall;
  logic [11:0]         wcnt;
  logic [TO_W-1:0]     tocnt;
  logic                startup;
  logic                sync_next;
  logic                synced;
  logic [BW-1:0]       baud;
  logic [PW-1:0]       bt;
  logic [2:0]          facc;
  logic [3:0]          idx;
  logic [2:0]          gcnt;
  logic [10:0]         rsh;
  logic [11:0]         tsh;
  logic [BW:0]         lowc;
  logic [BW:0]         brk_lim;
  logic                brk_seen;
  logic                brk_done;
  logic                dis_wr;
  logic                meter_done;
  logic                meter_bad;
  logic [BW-1:0]       meter_cnt;
  logic                bit_end;
  logic [PW-1:0]       next_bt;
  logic [2:0]          next_facc;
  logic                frac_carry;

  assign fall    = pin_q & ~pin_in;
  assign bit_end = tick && (bt == '0);
  assign dis_wr  = reg_wr && (reg_addr == pdl_pkg::DIS_OFF)
                   && reg_wdata[pdl_pkg::DIS_BIT];
  assign brk_done = brk_seen && pin_in;
  // Fractional bit length: low bits of the 8-bit count spread the remainder
  assign {frac_carry, next_facc} = {1'b0, facc} + {1'b0, baud[2:0]};
  assign next_bt = baud[BW-1:pdl_pkg::FRAC_W] - PW'(!frac_carry);
  assign brk_lim = (baud == '0) ? {1'b0, {BW{1'b1}}}
                 : {1'b0, baud} + {2'b00, baud[BW-1:1]};

  ////////////////////////////////////////////////////////////////////////////
  // Port clock enable

  always_ff @(posedge sys_clk) begin
    if (srst || tdiv == 5'h00) begin
      tdiv <= pdl_pkg::div_ratio(div_sel) - 5'h01;
    end else begin
      tdiv <= tdiv - 5'h01;
    end
    tick  <= !srst && (tdiv == 5'h00);
    pin_q <= pin_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Settings and register reads

  always_ff @(posedge sys_clk) begin
    if (srst || brk_done || dis_wr) begin
      gt_field <= pdl_pkg::GT_RESET;
      div_sel  <= pdl_pkg::DIV_RESET;
    end else if (reg_wr && reg_addr == pdl_pkg::GUARD_OFF) begin
      gt_field <= reg_wdata[2:0];
    end else if (reg_wr && reg_addr == pdl_pkg::ASI_OFF) begin
      div_sel  <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || !reg_rd) begin
      reg_rdata <= 8'h00;
    end else begin
      unique case (reg_addr)
        pdl_pkg::GUARD_OFF: reg_rdata <= {5'h00, gt_field};
        pdl_pkg::STATB_OFF: reg_rdata <= {5'h00, sig};
        pdl_pkg::ASI_OFF:   reg_rdata <= {6'h00, div_sel};
        pdl_pkg::STATE_OFF: reg_rdata <= {3'h0, sync_next, state};
        default:            reg_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Break detection: low longer than one and a half sync counts, a whole 12-bit frame

  always_ff @(posedge sys_clk) begin
    if (srst || pin_in || state == pdl_pkg::ST_DIS
        || state == pdl_pkg::ST_WAKE || state == pdl_pkg::ST_TX) begin
      lowc <= '0;
    end else if (tick && !(&lowc)) begin
      lowc <= lowc + 1'b1;
    end
    if (srst || brk_done || dis_wr) begin
      brk_seen <= 1'b0;
    end else if (lowc > brk_lim) begin
      brk_seen <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sync measurement

  pdl_sync_meter #(
    .W (BW)
  ) u_meter (
    .sys_clk (sys_clk),
    .srst    (srst),
    .tick    (tick),
    .arm     (state == pdl_pkg::ST_SYNC),
    .line    (pin_in),
    .done    (meter_done),
    .bad     (meter_bad),
    .count   (meter_cnt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Link sequencer

  always_ff @(posedge sys_clk) begin
    rx.valid      <= 1'b0;
    tx_done       <= 1'b0;
    sys_reset_req <= 1'b0;
    if (tick && bt != '0) begin
      bt <= bt - 1'b1;
    end
    if (reg_rd && reg_addr == pdl_pkg::STATB_OFF) begin
      sig <= pdl_pkg::SIG_NONE;
    end
    if (sync_req) begin
      sync_next <= 1'b1;
    end
    if (srst) begin
      state     <= pdl_pkg::ST_DIS;
      sig       <= pdl_pkg::SIG_NONE;
      clk_req   <= 1'b0;
      startup   <= 1'b1;
      sync_next <= 1'b1;
      synced    <= 1'b0;
      baud      <= '0;
      bt        <= '0;
      facc      <= 3'h0;
      idx       <= 4'h0;
      gcnt      <= 3'h0;
      wcnt      <= 12'h000;
      tocnt     <= '0;
      rsh       <= '0;
      tsh       <= '1;
      rx.data   <= 8'h00;
    end else if (dis_wr) begin
      state         <= pdl_pkg::ST_DIS;
      clk_req       <= 1'b0;
      sys_reset_req <= 1'b1;
      startup       <= 1'b1;
      sync_next     <= 1'b1;
      baud          <= '0;
    end else if (brk_done) begin
      state     <= pdl_pkg::ST_IDLE;
      sync_next <= 1'b1;
    end else if (acc_timeout && state != pdl_pkg::ST_DIS
                 && state != pdl_pkg::ST_WAKE && state != pdl_pkg::ST_WAIT
                 && state != pdl_pkg::ST_ERR) begin
      state <= pdl_pkg::ST_ERR;
      sig   <= pdl_pkg::SIG_ACCESS;
    end else begin
      unique case (state)
        pdl_pkg::ST_DIS: begin
          if (fall) begin
            state   <= pdl_pkg::ST_WAKE;
            clk_req <= 1'b1;
            wcnt    <= 12'h000;
          end
        end
        pdl_pkg::ST_WAKE: begin
          wcnt <= wcnt + 12'h001;
          if (wcnt == 12'(WAKE_TOTAL - 1)) begin
            state <= pdl_pkg::ST_WAIT;
            tocnt <= '0;
          end
        end
        pdl_pkg::ST_WAIT: begin
          if (fall) begin
            state <= pdl_pkg::ST_SYNC;
          end else if (tick) begin
            tocnt <= tocnt + 1'b1;
            if (tocnt == TO_W'(TIMEOUT_TICKS - 1)) begin
              state   <= pdl_pkg::ST_DIS;
              clk_req <= 1'b0;
            end
          end
        end
        pdl_pkg::ST_SYNC: begin
          // Meter sees the start edge one cycle late; host holds it low
          if (meter_bad) begin
            if (startup) begin
              state   <= pdl_pkg::ST_DIS;
              clk_req <= 1'b0;
            end else begin
              state <= pdl_pkg::ST_ERR;
              sig   <= pdl_pkg::SIG_FRAME;
            end
          end else if (meter_done) begin
            baud   <= meter_cnt;
            synced <= 1'b1;
          end
          if (synced && pin_in) begin
            state     <= pdl_pkg::ST_IDLE;
            startup   <= 1'b0;
            sync_next <= sync_req;
            synced    <= 1'b0;
          end
        end
        pdl_pkg::ST_IDLE: begin
          if (fall) begin
            // Sync is a normal frame, measured rather than decoded
            state <= sync_next ? pdl_pkg::ST_SYNC : pdl_pkg::ST_RX;
            bt    <= {1'b0, baud[BW-1:pdl_pkg::FRAC_W+1]};
            facc  <= 3'h0;
            idx   <= 4'h0;
          end else if (tx_valid && !tx_done) begin
            state <= pdl_pkg::ST_GUARD;
            gcnt  <= gt_field;
            bt    <= next_bt;
            facc  <= next_facc;
            tsh   <= {2'b11, ^tx_data, tx_data, 1'b0};
          end
        end
        pdl_pkg::ST_RX: begin
          if (bit_end) begin
            bt   <= next_bt;
            facc <= next_facc;
            idx  <= idx + 4'h1;
            rsh  <= {pin_in, rsh[10:1]};
            if (idx == 4'h0 && pin_in) begin
              state <= pdl_pkg::ST_IDLE;
            end else if (idx == pdl_pkg::FRAME_BITS - 4'h1) begin
              if (^rsh[9:1]) begin
                state <= pdl_pkg::ST_ERR;
                sig   <= pdl_pkg::SIG_PARITY;
              end else if (!rsh[10] || !pin_in) begin
                state <= pdl_pkg::ST_ERR;
                sig   <= pdl_pkg::SIG_FRAME;
              end else begin
                state    <= pdl_pkg::ST_IDLE;
                rx.valid <= 1'b1;
                rx.data  <= rsh[8:1];
              end
            end
          end
        end
        pdl_pkg::ST_GUARD: begin
          if (bit_end) begin
            bt   <= next_bt;
            facc <= next_facc;
            if (gcnt == 3'h0) begin
              state <= pdl_pkg::ST_TX;
              idx   <= 4'h0;
            end else begin
              gcnt <= gcnt - 3'h1;
            end
          end
        end
        pdl_pkg::ST_TX: begin
          if (bit_end) begin
            bt   <= next_bt;
            facc <= next_facc;
            idx  <= idx + 4'h1;
            tsh  <= {1'b1, tsh[11:1]};
            if (pin_out && !pin_in) begin
              state <= pdl_pkg::ST_ERR;
              sig   <= pdl_pkg::SIG_CONTENTION;
            end else if (idx == pdl_pkg::FRAME_BITS - 4'h1) begin
              state   <= pdl_pkg::ST_IDLE;
              tx_done <= 1'b1;
            end
          end
        end
        pdl_pkg::ST_ERR: begin
          // Only the break and disable-write paths above leave this state
          state <= pdl_pkg::ST_ERR;
        end
        default: state <= pdl_pkg::ST_DIS;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive and status

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pin_oe       <= 1'b0;
      pin_out      <= 1'b1;
      port_enabled <= 1'b0;
      error_active <= 1'b0;
    end else begin
      pin_oe  <= (state == pdl_pkg::ST_WAKE)
                 || (state == pdl_pkg::ST_TX);
      pin_out <= (state == pdl_pkg::ST_TX) ? tsh[0] : 1'b0;
      port_enabled <= (state != pdl_pkg::ST_DIS) && !startup;
      error_active <= (state == pdl_pkg::ST_ERR);
    end
  end

endmodule

/* pdl_link_chk.sv */
`timescale 1ns/1ns
module pdl_link_chk #(
  parameter int TIMEOUT_TICKS = 65536,
  parameter int CAL_CYC       = 16
) (
  // Clock and reset
  input wire logic             sys_clk,
  input wire logic             srst,
  // Register port
  input wire logic [3:0]       reg_addr,
  input wire logic [7:0]       reg_wdata,
  input wire logic             reg_wr,
  input wire logic             reg_rd,
  input wire logic [7:0]       reg_rdata,
  // Pin and link
  input wire logic             pin_in,
  input wire logic             pin_out,
  input wire logic             pin_oe,
  input wire pdl_pkg::pdl_rx_t rx,
  input wire logic             tx_valid,
  input wire logic             acc_timeout,
  // System
  input wire logic             clk_req,
  input wire logic             sys_reset_req,
  input wire logic             port_enabled,
  input wire logic             error_active
);
  localparam int HOLD  = pdl_pkg::WAKE_CYC + CAL_CYC;
  // Slowest divider bounds the wait; margin covers tick phase
  localparam int LIMIT = TIMEOUT_TICKS * 25 + 60;
  logic [31:0] hold_cnt;
  logic [31:0] idle_cnt;
  wire logic   dis_wr = reg_wr && reg_addr == pdl_pkg::DIS_OFF
                        && reg_wdata[pdl_pkg::DIS_BIT];
  always_ff @(posedge sys_clk)
    hold_cnt <= (srst || !pin_oe || pin_out) ? 32'h0 : hold_cnt + 32'h1;
  always_ff @(posedge sys_clk)
    idle_cnt <= (srst || !clk_req || port_enabled || pin_oe || !pin_in)
                ? 32'h0 : idle_cnt + 32'h1;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  rdata_quiet_a: assert property (
    reg_rdata != 8'h00 |-> $past(reg_rd)) else $error("stray read data");
  dis_reset_a: assert property (
    dis_wr |=> sys_reset_req ##[0:2] (!clk_req && !port_enabled))
    else $error("disable write not honoured");
  reset_cause_a: assert property (
    sys_reset_req |-> $past(dis_wr)) else $error("reset without write");
  rx_gate_a: assert property (
    rx.valid |-> port_enabled && !error_active) else $error("rx while off");
  wake_hold_a: assert property (
    $fell(pin_oe) && !port_enabled |-> hold_cnt == HOLD)
    else $error("wake hold length wrong");
  start_timeout_a: assert property (
    idle_cnt < LIMIT) else $error("start-up wait too long");
  tx_start_a: assert property (
    $rose(pin_oe) && port_enabled |-> !pin_out && tx_valid)
    else $error("bad frame start");
  acc_err_a: assert property (
    acc_timeout && port_enabled |-> ##[1:2] error_active)
    else $error("access error not entered");
endmodule
bind pdl_link pdl_link_chk #(
  .TIMEOUT_TICKS(TIMEOUT_TICKS),
  .CAL_CYC(CAL_CYC)
) pdl_link_chk_inst (
  .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe(pin_oe), .rx(rx), .tx_valid(tx_valid),
  .acc_timeout(acc_timeout), .clk_req(clk_req),
  .sys_reset_req(sys_reset_req), .port_enabled(port_enabled),
  .error_active(error_active)
);

/* pdl_host.sv */
`timescale 1ns/1ns
module pdl_host (
  // Clock
  input  wire logic sys_clk,
  // Pin, pulled up, host only pulls low
  input  wire logic pin,
  output logic      host_low
);
  // Four port ticks per bit at the slowest divider
  int bit_cyc = 100;
  initial host_low = 1'b0;
  task automatic hold(input logic lvl, input int n);
    @(posedge sys_clk);
    host_low <= !lvl;
    repeat (n - 1) @(posedge sys_clk);
  endtask
  task automatic send(input logic [7:0] d, input logic bad_par);
    hold(1'b0, bit_cyc);
    for (int i = 0; i < 8; i++) hold(d[i], bit_cyc);
    hold(^d ^ bad_par, bit_cyc);
    hold(1'b1, 2 * bit_cyc);
  endtask
  // Second break catches a port that was busy at the first
  task automatic brk();
    repeat (2) begin
      hold(1'b0, 14 * bit_cyc);
      hold(1'b1, 2 * bit_cyc);
    end
  endtask
  task automatic wake(output int n);
    hold(1'b0, 30);
    hold(1'b1, 1);
    for (n = 0; n < 3000 && pin !== 1'b1; n++) @(posedge sys_clk);
  endtask
  // Mid-bit sampling, gap counted up to the start bit
  task automatic recv(output logic [7:0] d, output int gap, output logic p);
    for (gap = 0; gap < 5000 && pin !== 1'b0; gap++) @(posedge sys_clk);
    repeat (bit_cyc + bit_cyc / 2) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      d[i] = pin;
      repeat (bit_cyc) @(posedge sys_clk);
    end
    p = pin;
  endtask
endmodule

/* testbench.sv */
`timescale 1ns/1ns
module testbench;
  logic             sys_clk = 1'b0;
  logic             srst = 1'b1;
  logic [3:0]       reg_addr = 4'h0;
  logic [7:0]       reg_wdata = 8'h00;
  logic [7:0]       tx_data = 8'h00;
  logic             reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
  logic             sync_req = 1'b0, tx_valid = 1'b0, acc_timeout = 1'b0;
  logic [7:0]       reg_rdata;
  logic             pin_out, pin_oe, host_low, tx_done, clk_req;
  logic             sys_reset_req, port_enabled, error_active;
  pdl_pkg::pdl_rx_t rx;
  logic [7:0]       rq[$];
  logic [7:0]       xq[$];
  int               fail_count = 0;
  int               check_count = 0;
  wire logic        pin = !(pin_oe && !pin_out) && !host_low;
  always #5 sys_clk = ~sys_clk;
  pdl_link #(.TIMEOUT_TICKS(64)) pdl_link_inst (
    .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pin_in(pin), .pin_out(pin_out),
    .pin_oe(pin_oe), .rx(rx), .sync_req(sync_req), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_done(tx_done), .acc_timeout(acc_timeout),
    .clk_req(clk_req), .sys_reset_req(sys_reset_req),
    .port_enabled(port_enabled), .error_active(error_active)
  );
  pdl_host pdl_host_inst (.sys_clk(sys_clk), .pin(pin), .host_low(host_low));
  task automatic chk(input string n, input logic [31:0] e, s);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic close_out();
    if (fail_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [2:0] e);
    rq.push_back({5'h00, e});
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask
  task automatic sync();
    pdl_host_inst.send(pdl_pkg::SYNC_DATA, 1'b0);
  endtask
  task automatic instr(input logic [7:0] d);
    xq.push_back(d);
    pdl_host_inst.send(d, 1'b0);
  endtask
  task automatic send_tx(input logic [7:0] d);
    @(posedge sys_clk);
    tx_valid <= 1'b1;
    tx_data <= d;
    for (int i = 0; i < 5000 && tx_done !== 1'b1; i++) @(posedge sys_clk);
    chk("tx_done", 1, tx_done);
    tx_valid <= 1'b0;
  endtask
  // Results are compared in order of arrival
  always @(posedge sys_clk) begin
    if (rd_d) chk("reg_rdata", rq.pop_front(), reg_rdata);
    if (rx.valid === 1'b1 && xq.size() == 0) chk("rx extra", 0, 1);
    else if (rx.valid === 1'b1)
      chk("rx.data", xq.pop_front(), rx.data);
    rd_d <= reg_rd;
  end
  initial begin
    repeat (80000) @(posedge sys_clk);
    fail_count++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d;
    logic [7:0] xd;
    logic [2:0] gts[3];
    int n;
    logic p;
    gts = '{3'h0, 3'h2, 3'h7};
    void'($urandom(82212));
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    rd(pdl_pkg::GUARD_OFF, pdl_pkg::GT_RESET);
    rd(pdl_pkg::ASI_OFF, {1'b0, pdl_pkg::DIV_RESET});
    rd(pdl_pkg::DIS_OFF, 3'h0);
    rd(4'h9, 3'h0);
    pdl_host_inst.wake(n);
    chk("wake hold", 1, n > 770 && n < 805);
    chk("clk_req", 1, clk_req);
    sync();
    chk("enabled", 1, port_enabled);
    instr(8'ha3);
    d = 8'($urandom);
    @(posedge sys_clk);
    sync_req <= 1'b1;
    @(posedge sys_clk);
    sync_req <= 1'b0;
    sync();
    instr(d);
    foreach (gts[i]) begin
      wr(pdl_pkg::GUARD_OFF, {5'h00, gts[i]});
      rd(pdl_pkg::GUARD_OFF, gts[i]);
      d = 8'($urandom);
      fork
        pdl_host_inst.recv(xd, n, p);
        send_tx(d);
      join
      chk("tx data", d, xd);
      chk("tx parity", ^d, p);
      // First idle bit starts at a free-running tick, so it may run short
      chk("gap", 1, n >= gts[i] * 100 + 50
          && n < gts[i] * 100 + 260);
    end
    pdl_host_inst.send(8'h3c, 1'b1);
    chk("parity err", 1, error_active);
    pdl_host_inst.send(8'h3c, 1'b0);
    wr(pdl_pkg::ASI_OFF, 8'h00);
    rd(pdl_pkg::ASI_OFF, 3'h0);
    wr(pdl_pkg::GUARD_OFF, 8'h05);
    pdl_host_inst.brk();
    chk("err cleared", 0, error_active);
    rd(pdl_pkg::ASI_OFF, {1'b0, pdl_pkg::DIV_RESET});
    rd(pdl_pkg::GUARD_OFF, pdl_pkg::GT_RESET);
    sync();
    rd(pdl_pkg::STATB_OFF, pdl_pkg::SIG_PARITY);
    rd(pdl_pkg::STATB_OFF, 3'h0);
    instr(8'h81);
    @(posedge sys_clk);
    acc_timeout <= 1'b1;
    @(posedge sys_clk);
    acc_timeout <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("access err", 1, error_active);
    pdl_host_inst.brk();
    sync();
    rd(pdl_pkg::STATB_OFF, pdl_pkg::SIG_ACCESS);
    wr(pdl_pkg::DIS_OFF, 8'h04);
    repeat (3) @(posedge sys_clk);
    chk("disabled", 0, port_enabled);
    chk("dis clk_req", 0, clk_req);
    pdl_host_inst.wake(n);
    repeat (1550) @(posedge sys_clk);
    chk("timeout early", 1, clk_req);
    repeat (110) @(posedge sys_clk);
    chk("timeout", 0, clk_req);
    pdl_host_inst.wake(n);
    pdl_host_inst.bit_cyc = 25;
    sync();
    pdl_host_inst.bit_cyc = 100;
    chk("short sync", 0, clk_req);
    chk("rx left", 0, xq.size());
    close_out();
  end
endmodule
